/* File: urb_pkg.sv */
package urb_pkg;

    // apb address map, byte addresses of aligned 32-bit words
    localparam int          APB_ADDR_W       = 12;
    localparam logic [11:0] OFS_STATUS_A     = 12'h000;
    localparam logic [11:0] OFS_CONTROL_B    = 12'h004;
    localparam logic [11:0] OFS_CONTROL_C    = 12'h008;
    localparam logic [11:0] OFS_DATA         = 12'h00C;

    // status register a bit positions
    localparam int          STA_RX_COMPLETE  = 7;
    localparam int          STA_FRAME_ERR    = 4;
    localparam int          STA_OVERRUN      = 3;
    localparam int          STA_PARITY_ERR   = 2;

    // control register b bit positions
    localparam int          CTB_RX_IRQ_EN    = 7;
    localparam int          CTB_RX_ENABLE    = 4;
    localparam int          CTB_SIZE_HI      = 2;
    localparam int          CTB_RX_NINTH     = 1;
    localparam int          CTB_TX_NINTH     = 0;

    // control register c bit positions
    localparam int          CTC_PAR_UPPER    = 5;
    localparam int          CTC_PAR_LOWER    = 4;
    localparam int          CTC_STOP_SEL     = 3;
    localparam int          CTC_SIZE_LO_HI   = 2;
    localparam int          CTC_SIZE_LO_LO   = 1;

    // reset values of the software fields
    localparam logic [2:0]  RST_CHAR_SIZE    = 3'h3;
    localparam logic [1:0]  RST_PARITY_MODE  = 2'h0;

    // character size codes and their data masks
    localparam logic [2:0]  SIZE_5_BITS      = 3'h0;
    localparam logic [2:0]  SIZE_6_BITS      = 3'h1;
    localparam logic [2:0]  SIZE_7_BITS      = 3'h2;
    localparam logic [2:0]  SIZE_8_BITS      = 3'h3;
    localparam logic [2:0]  SIZE_9_BITS      = 3'h7;
    localparam logic [8:0]  MASK_5_BITS      = 9'h01F;
    localparam logic [8:0]  MASK_6_BITS      = 9'h03F;
    localparam logic [8:0]  MASK_7_BITS      = 9'h07F;
    localparam logic [8:0]  MASK_8_BITS      = 9'h0FF;
    localparam logic [8:0]  MASK_9_BITS      = 9'h1FF;

    // receive buffer entry layout
    localparam int          DATA_W           = 9;
    localparam int          ENT_FRAME_ERR    = 9;
    localparam int          ENT_OVERRUN      = 10;
    localparam int          ENT_PARITY_ERR   = 11;
    localparam int          ENTRY_W          = 12;
    localparam int          FIFO_DEPTH       = 2;

endpackage

/* File: urb_fifo2.sv */
`timescale 1ns/1ps
module urb_fifo2
    import urb_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               flush,
    input  wire logic               push,
    input  wire logic [ENTRY_W-1:0] push_entry,
    input  wire logic               pop,
    output logic      [ENTRY_W-1:0] head_entry,
    output logic                    full,
    output logic                    empty
);

    logic [ENTRY_W-1:0] mem_q [FIFO_DEPTH];
    logic               wr_ptr_q;
    logic               rd_ptr_q;
    logic [1:0]         count_q;
    logic [1:0]         count_d;
    logic               do_push;
    logic               do_pop;

    // a push into a full buffer or a pop of an empty one is dropped
    assign empty   = (count_q == 2'h0);
    assign full    = (count_q == 2'h2);
    assign do_push = push & ~full & ~flush;
    assign do_pop  = pop & ~empty & ~flush;
    assign count_d = count_q + {1'b0, do_push} - {1'b0, do_pop};

    // head comes straight from the storage flops
    assign head_entry = mem_q[rd_ptr_q];

    // storage per entry, written at the write pointer
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[i] <= '0;
            end else if (do_push && (wr_ptr_q == 1'(i))) begin
                mem_q[i] <= push_entry;
            end
        end
    end

    // pointers and fill count; flush empties at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else if (flush) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ do_push;
            rd_ptr_q <= rd_ptr_q ^ do_pop;
            count_q  <= count_d;
        end
    end

endmodule

/* File: urb_rx_status.sv */
`timescale 1ns/1ps
// How it works
// RL1 - software reads ninth bit, status before data
// RL2 - data read advances buffer to next entry
// RL3 - receive complete flag set while unread data
// RL4 - clearing enable flushes buffer, clears complete
// RL5 - interrupt follows complete flag and enables
// RL6 - handler reads data to drop interrupt
// RL7 - error flags stored with frame, read status
// RL8 - software writes never change error flags
// RL9 - software writes zeros to error flags
// RL10 - error flags raise no interrupt
// RL11 - frame error reflects first stop bit
// RL12 - stop count setting ignored by frame error
// RL13 - overrun on start while buffer, shifter full
// RL14 - overrun clears on successful buffer transfer
// RL15 - upper parity bit enables, lower selects odd
// RL16 - parity result computed and stored with data
// RL17 - parity flag from head entry when enabled
// RL18 - parity flag reads zero when checking off
// RL19 - disabling receiver is immediate, aborts frame
// RL20 - disabled receiver releases receive pin
// RL21 - software flushes by reading until empty
// RL22 - completed frame moves from shifter to buffer
// RL23 - unused upper data bits read zero
// RL24 - enabling receiver takes over receive pin
// RL25 - two-entry buffer holding data and flags
module urb_rx_status
    import urb_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // apb slave
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // receive shift register side
    input  wire logic                  frame_done,
    input  wire logic [DATA_W-1:0]     frame_data,
    input  wire logic                  frame_stop_bit,
    input  wire logic                  frame_parity_bit,
    input  wire logic                  start_detect,
    output logic                       rx_abort,
    output logic                       rx_pin_override,
    output logic      [2:0]            char_size_select,
    output logic                       stop_bit_count_select,
    output logic                       parity_mode_upper,
    output logic                       parity_mode_lower,
    output logic                       tx_ninth_bit,
    // interrupt request towards the core
    input  wire logic                  global_irq_enable,
    output logic                       rx_irq
);

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_sync_n;

    // asynchronous assert, two-flop release; only the second flop is used
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_sync_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    logic lane0_wr;
    logic hit_status;
    logic hit_ctrl_b;
    logic hit_ctrl_c;
    logic hit_data;
    logic addr_ok;

    // every access finishes in its first access cycle
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable;
    assign apb_wr     = apb_access & pwrite;
    assign lane0_wr   = apb_wr & pstrb[0];  // all fields live in byte 0
    assign hit_status = (paddr == OFS_STATUS_A);
    assign hit_ctrl_b = (paddr == OFS_CONTROL_B);
    assign hit_ctrl_c = (paddr == OFS_CONTROL_C);
    assign hit_data   = (paddr == OFS_DATA);
    assign addr_ok    = hit_status | hit_ctrl_b | hit_ctrl_c | hit_data;
    assign pready     = 1'b1;
    assign pslverr    = apb_access & ~addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // software control fields

    logic       rx_en_q;
    logic       irq_en_q;
    logic       size_hi_q;
    logic [1:0] size_lo_q;
    logic       tx_ninth_q;
    logic       stop_sel_q;
    logic [1:0] par_mode_q;

    // writes to the status word are dropped: error flags are not writable
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_en_q    <= 1'b0;
            irq_en_q   <= 1'b0;
            size_hi_q  <= RST_CHAR_SIZE[2];
            tx_ninth_q <= 1'b0;
        end else if (lane0_wr && hit_ctrl_b) begin  // RL8
            rx_en_q    <= pwdata[CTB_RX_ENABLE];
            irq_en_q   <= pwdata[CTB_RX_IRQ_EN];
            size_hi_q  <= pwdata[CTB_SIZE_HI];
            tx_ninth_q <= pwdata[CTB_TX_NINTH];
        end
    end

    // control c: parity mode, stop count, low size bits
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            size_lo_q  <= RST_CHAR_SIZE[1:0];
            stop_sel_q <= 1'b0;
            par_mode_q <= RST_PARITY_MODE;
        end else if (lane0_wr && hit_ctrl_c) begin
            size_lo_q  <= pwdata[CTC_SIZE_LO_HI:CTC_SIZE_LO_LO];
            stop_sel_q <= pwdata[CTC_STOP_SEL];
            par_mode_q <= {pwdata[CTC_PAR_UPPER], pwdata[CTC_PAR_LOWER]};
        end
    end

    // stop count only feeds the transmitter, never the frame check
    assign char_size_select      = {size_hi_q, size_lo_q};
    assign stop_bit_count_select = stop_sel_q;  // RL12
    assign parity_mode_upper     = par_mode_q[1];
    assign parity_mode_lower     = par_mode_q[0];
    assign tx_ninth_bit          = tx_ninth_q;

    // receiver owns the pin only while enabled; abort is immediate
    assign rx_pin_override = rx_en_q;  // RL20 RL24
    assign rx_abort        = ~rx_en_q;  // RL19

    ////////////////////////////////////////////////////////////////////////
    // incoming frame: masking, frame and parity checks

    logic [DATA_W-1:0]  size_mask;
    logic [DATA_W-1:0]  frame_masked;
    logic               frame_ok;
    logic               frame_fe;
    logic               frame_pe;
    logic [ENTRY_W-1:0] frame_entry;

    // undefined size codes fall back to eight bits
    assign size_mask =
        (char_size_select == SIZE_5_BITS) ? MASK_5_BITS :
        (char_size_select == SIZE_6_BITS) ? MASK_6_BITS :
        (char_size_select == SIZE_7_BITS) ? MASK_7_BITS :
        (char_size_select == SIZE_9_BITS) ? MASK_9_BITS :
                                            MASK_8_BITS;

    // frames finishing while disabled are thrown away
    assign frame_ok     = frame_done & rx_en_q;  // RL19
    assign frame_masked = frame_data & size_mask;  // RL23
    assign frame_fe     = ~frame_stop_bit;  // RL11 RL12
    // even: data xor parity must be 0; odd: must be 1
    assign frame_pe     = par_mode_q[1]
                        & (^frame_masked ^ frame_parity_bit
                           ^ par_mode_q[0]);  // RL15 RL16 RL17

    // overrun bit is filled in at the moment of transfer
    assign frame_entry  = {frame_pe, 1'b0, frame_fe, frame_masked};  // RL16

    ////////////////////////////////////////////////////////////////////////
    // shift register hold stage and overrun

    logic               fifo_full;
    logic               fifo_empty;
    logic               fifo_push;
    logic               fifo_pop;
    logic               flush;
    logic [ENTRY_W-1:0] push_entry;
    logic [ENTRY_W-1:0] head_entry;
    logic               hold_valid_q;
    logic [ENTRY_W-1:0] hold_entry_q;
    logic               push_hold;
    logic               push_direct;
    logic               hold_load;
    logic               ovr_set;
    logic               ovr_pend_q;

    // a disabled receiver keeps the buffer flushed
    assign flush = ~rx_en_q;  // RL4

    // a frame waits in the shifter while the buffer is full
    assign push_hold   = hold_valid_q & ~fifo_full;  // RL22
    assign push_direct = frame_ok & ~hold_valid_q & ~fifo_full;  // RL22
    assign hold_load   = frame_ok & (hold_valid_q | fifo_full);
    assign fifo_push   = (push_hold | push_direct) & rx_en_q;

    // start seen with buffer and shifter both full: a frame gets lost
    assign ovr_set = start_detect & rx_en_q & fifo_full
                   & hold_valid_q;  // RL13

    // the first frame stored after a loss carries the overrun mark
    assign push_entry = push_hold
        ? {hold_entry_q[ENT_PARITY_ERR], ovr_pend_q,
           hold_entry_q[ENT_FRAME_ERR:0]}
        : {frame_entry[ENT_PARITY_ERR], ovr_pend_q,
           frame_entry[ENT_FRAME_ERR:0]};  // RL7 RL13

    // hold stage: a newer frame overwrites a waiting one (data lost while the buffer is full)
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_valid_q <= 1'b0;
            hold_entry_q <= '0;
        end else if (flush) begin
            hold_valid_q <= 1'b0;
        end else if (hold_load) begin
            hold_valid_q <= 1'b1;
            hold_entry_q <= frame_entry;
        end else if (push_hold) begin
            hold_valid_q <= 1'b0;
        end
    end

    // loss marker: set beats clear; cleared by the next good transfer
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ovr_pend_q <= 1'b0;
        end else if (flush) begin
            ovr_pend_q <= 1'b0;
        end else if (ovr_set) begin
            ovr_pend_q <= 1'b1;  // RL13
        end else if (fifo_push) begin
            ovr_pend_q <= 1'b0;  // RL14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry receive buffer

    // head entry drives the error flags and ninth bit that software reads
    urb_fifo2 u_fifo (  // RL25
        .sys_clk    (sys_clk),
        .rst_n      (rst_sync_n),
        .flush      (flush),
        .push       (fifo_push),
        .push_entry (push_entry),
        .pop        (fifo_pop),
        .head_entry (head_entry),
        .full       (fifo_full),
        .empty      (fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // status view and read path

    logic        rx_complete;
    logic        head_fe;
    logic        head_dor;
    logic        head_upe;
    logic [7:0]  status_byte;
    logic [7:0]  ctrl_b_byte;
    logic [7:0]  ctrl_c_byte;
    logic [31:0] read_mux;
    logic        rd_valid_q;
    logic [31:0] prdata_q;

    // complete flag is the buffer's non-empty level, zero once disabled
    assign rx_complete = ~fifo_empty & rx_en_q;  // RL3 RL4
    // flags of an empty buffer read zero
    assign head_fe     = rx_complete & head_entry[ENT_FRAME_ERR];  // RL11
    assign head_dor    = rx_complete & head_entry[ENT_OVERRUN];  // RL7
    assign head_upe    = rx_complete & head_entry[ENT_PARITY_ERR]
                       & par_mode_q[1];  // RL17 RL18

    // status word; unlisted bits read zero
    always_comb begin
        status_byte                  = 8'h00;
        status_byte[STA_RX_COMPLETE] = rx_complete;
        status_byte[STA_FRAME_ERR]   = head_fe;  // RL7
        status_byte[STA_OVERRUN]     = head_dor;  // RL7
        status_byte[STA_PARITY_ERR]  = head_upe;  // RL7
    end

    // control words; the ninth bit follows the head entry
    always_comb begin
        ctrl_b_byte                = 8'h00;
        ctrl_b_byte[CTB_RX_IRQ_EN] = irq_en_q;
        ctrl_b_byte[CTB_RX_ENABLE] = rx_en_q;
        ctrl_b_byte[CTB_SIZE_HI]   = size_hi_q;
        ctrl_b_byte[CTB_RX_NINTH]  = rx_complete & head_entry[DATA_W-1];
        ctrl_b_byte[CTB_TX_NINTH]  = tx_ninth_q;
        ctrl_c_byte                = 8'h00;
        ctrl_c_byte[CTC_PAR_UPPER] = par_mode_q[1];
        ctrl_c_byte[CTC_PAR_LOWER] = par_mode_q[0];
        ctrl_c_byte[CTC_STOP_SEL]  = stop_sel_q;
        ctrl_c_byte[CTC_SIZE_LO_HI:CTC_SIZE_LO_LO] = size_lo_q;
    end

    // data read shows the low eight bits; masked bits are already zero
    assign read_mux =
        hit_status ? {24'h000000, status_byte} :
        hit_ctrl_b ? {24'h000000, ctrl_b_byte} :
        hit_ctrl_c ? {24'h000000, ctrl_c_byte} :
        hit_data   ? {24'h000000,
                      rx_complete ? head_entry[7:0] : 8'h00} :
                     32'h00000000;  // RL23

    // sampled in setup so prdata comes from a flop in the access cycle
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata_q   <= 32'h00000000;
            rd_valid_q <= 1'b0;
        end else if (apb_setup) begin
            prdata_q   <= pwrite ? 32'h00000000 : read_mux;
            rd_valid_q <= rx_complete;
        end
    end

    assign prdata = prdata_q;

    // pop only what setup saw: a frame landing after it stays unread
    assign fifo_pop = apb_access & ~pwrite & hit_data
                    & rd_valid_q;  // RL2 RL6 RL21

    ////////////////////////////////////////////////////////////////////////
    // interrupt request

    logic rx_irq_q;

    // level request; error flags deliberately take no part
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= irq_en_q & rx_complete
                      & global_irq_enable;  // RL5 RL10
        end
    end

    assign rx_irq = rx_irq_q;

endmodule

/* File: urb_rx_status_asserts.sv */
`timescale 1ns/1ps
module urb_rx_status_asserts
    import urb_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic                  rx_abort,
    input wire logic                  rx_pin_override,
    input wire logic                  parity_mode_upper,
    input wire logic                  global_irq_enable,
    input wire logic                  rx_irq
);
    // access-phase decodes
    wire acc  = psel && penable;
    wire wr_b = acc && pwrite && pstrb[0] && paddr == OFS_CONTROL_B;
    wire wr_c = acc && pwrite && pstrb[0] && paddr == OFS_CONTROL_C;
    wire rd_s = acc && !pwrite && paddr == OFS_STATUS_A;
    wire rd_d = acc && !pwrite && paddr == OFS_DATA;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_pin_owner: assert property
        (wr_b |=> rx_pin_override == $past(pwdata[CTB_RX_ENABLE]))
        else $error("pin override not taken from enable write");
    a_disable_now: assert property
        (wr_b |=> rx_abort == !$past(pwdata[CTB_RX_ENABLE]))
        else $error("receiver enable write not applied at once");
    a_parity_set: assert property
        (wr_c |=> parity_mode_upper == $past(pwdata[CTC_PAR_UPPER]))
        else $error("parity check enable not taken from write");
    a_irq_global: assert property (rx_irq |-> $past(global_irq_enable))
        else $error("interrupt raised while globally masked");
    a_irq_flushed: assert property (rx_abort [*3] |-> !rx_irq)
        else $error("interrupt held with receiver disabled");
    a_parity_off: assert property
        (rd_s && !$past(parity_mode_upper) |-> !prdata[STA_PARITY_ERR])
        else $error("parity flag set while checking off");
    a_empty_flags: assert property
        (rd_s && $past(rx_abort) && $past(rx_abort, 2)
            |-> !prdata[7] && prdata[4:2] == 3'h0)
        else $error("status flags set after flush");
    a_data_high: assert property (rd_d |-> prdata[31:8] == 24'h0)
        else $error("upper data bits not zero");
    // main scenarios
    c_irq: cover property (rx_irq);
    c_overrun: cover property (rd_s && prdata[STA_OVERRUN]);
    c_unmapped: cover property (acc && pslverr);
endmodule

bind urb_rx_status urb_rx_status_asserts i_urb_rx_status_asserts (
    .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pslverr, .rx_abort, .rx_pin_override, .parity_mode_upper,
    .global_irq_enable, .rx_irq);

/* File: urb_frame_src.sv */
`timescale 1ns/1ps
module urb_frame_src (
    input  wire logic       sys_clk,
    output logic            frame_done,
    output logic [8:0]      frame_data,
    output logic            frame_stop_bit,
    output logic            frame_parity_bit,
    output logic            start_detect
);
    // idle levels until the first frame
    initial begin
        frame_done = 1'b0;
        frame_data = 9'h0AA;
        frame_stop_bit = 1'b1;
        frame_parity_bit = 1'b0;
        start_detect = 1'b0;
    end
    // one finished frame; lines inverted after it so stale data looks wrong
    task automatic send(input logic [8:0] d, input logic sb, input logic pb);
        frame_done <= 1'b1;
        frame_data <= d;
        frame_stop_bit <= sb;
        frame_parity_bit <= pb;
        @(posedge sys_clk);
        frame_done <= 1'b0;
        frame_data <= ~d;
        frame_stop_bit <= ~sb;
        frame_parity_bit <= ~pb;
        @(posedge sys_clk);
    endtask
    // a new start bit seen by the sampler
    task automatic start();
        start_detect <= 1'b1;
        @(posedge sys_clk);
        start_detect <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end end
module testbench
    import urb_pkg::*;
;
    logic        sys_clk = 1'b0, rst_n = 1'b0, global_irq_enable = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, e, rx_abort, rx_pin_override, rx_irq;
    logic        frame_done, frame_stop_bit, frame_parity_bit, start_detect;
    logic [8:0]  frame_data;
    logic        stop_bit_count_select, parity_mode_upper, parity_mode_lower;
    logic        tx_ninth_bit;
    logic [2:0]  char_size_select, sz;
    logic [2:0]  szs [5] = '{SIZE_5_BITS, SIZE_6_BITS, SIZE_7_BITS,
                            SIZE_8_BITS, SIZE_9_BITS};
    logic [8:0]  msk [5] = '{MASK_5_BITS, MASK_6_BITS, MASK_7_BITS,
                            MASK_8_BITS, MASK_9_BITS};
    int          bad_count = 0, checks = 0;
    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;
    urb_rx_status i_urb_rx_status (.sys_clk, .rst_n, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .frame_done, .frame_data, .frame_stop_bit, .frame_parity_bit,
        .start_detect, .rx_abort, .rx_pin_override, .char_size_select,
        .stop_bit_count_select, .parity_mode_upper, .parity_mode_lower,
        .tx_ninth_bit, .global_irq_enable, .rx_irq);
    urb_frame_src i_urb_frame_src (.sys_clk, .frame_done, .frame_data,
        .frame_stop_bit, .frame_parity_bit, .start_detect);
    ////////////////////////////////////////////////////////////////////////
    // one apb transfer, then an idle edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                      input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, r)
    endtask
    // level output, sampled mid-cycle
    task automatic pin(input string nm, input logic ex);
        @(negedge sys_clk);
        case (nm)
            "rx_irq": `CHK(nm, ex, rx_irq)
            "rx_abort": `CHK(nm, ex, rx_abort)
            default: `CHK(nm, ex, rx_pin_override)
        endcase
        @(posedge sys_clk);
    endtask
    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the length of the tests
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // setup, readback and an unmapped access
        apb(1'b1, OFS_CONTROL_B, 32'h90);
        apb(1'b1, OFS_CONTROL_C, 32'h2E);
        rd(OFS_CONTROL_C, 32'h2E, "ctrl_c");
        `CHK("stop_sel", 1'b1, stop_bit_count_select)
        rd(12'h010, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, e)
        // error flags travel with their frames
        i_urb_frame_src.send(9'h05A, 1'b1, 1'b0);
        i_urb_frame_src.send(9'h03C, 1'b0, 1'b1);
        pin("rx_irq", 1'b1);
        rd(OFS_STATUS_A, 32'h80, "status");
        apb(1'b1, OFS_STATUS_A, 32'h1C);
        rd(OFS_STATUS_A, 32'h80, "status");
        rd(OFS_DATA, 32'h5A, "data");
        rd(OFS_STATUS_A, 32'h94, "status");
        rd(OFS_DATA, 32'h3C, "data");
        pin("rx_irq", 1'b0);
        apb(1'b1, OFS_STATUS_A, 32'h0);
        // overrun: buffer and hold full, then a start bit
        apb(1'b1, OFS_CONTROL_C, 32'h36);
        `CHK("par_lower", 1'b1, parity_mode_lower)
        i_urb_frame_src.send(9'h011, 1'b1, 1'b1);
        i_urb_frame_src.send(9'h022, 1'b1, 1'b1);
        i_urb_frame_src.send(9'h033, 1'b1, 1'b0);
        i_urb_frame_src.start();
        rd(OFS_DATA, 32'h11, "data");
        rd(OFS_STATUS_A, 32'h80, "status");
        rd(OFS_DATA, 32'h22, "data");
        rd(OFS_STATUS_A, 32'h8C, "status");
        rd(OFS_DATA, 32'h33, "data");
        i_urb_frame_src.send(9'h044, 1'b1, 1'b1);
        rd(OFS_STATUS_A, 32'h80, "status");
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, OFS_STATUS_A, 32'h0);
            if (r[STA_RX_COMPLETE] === 1'b1)
                apb(1'b0, OFS_DATA, 32'h0);
        end
        rd(OFS_STATUS_A, 32'h0, "status");
        // every character size, parity off with the parity bit set
        for (int i = 0; i < 5; i++) begin
            sz = szs[i];
            apb(1'b1, OFS_CONTROL_B, {29'h12, sz[2], 2'h0});
            apb(1'b1, OFS_CONTROL_C, {29'h0, sz[1:0], 1'b0});
            `CHK("char_size", sz, char_size_select)
            i_urb_frame_src.send(9'h1FF, 1'b1, 1'b1);
            rd(OFS_CONTROL_B, {29'h12, sz[2], sz[2], 1'b0}, "ctrl_b");
            rd(OFS_STATUS_A, 32'h80, "status");
            rd(OFS_DATA, {24'h0, msk[i][7:0]}, "data");
        end
        // global mask, then disable with data buffered
        global_irq_enable <= 1'b0;
        i_urb_frame_src.send(9'h055, 1'b1, 1'b0);
        i_urb_frame_src.send(9'h066, 1'b1, 1'b0);
        pin("rx_irq", 1'b0);
        global_irq_enable <= 1'b1;
        @(posedge sys_clk);
        pin("rx_irq", 1'b1);
        apb(1'b1, OFS_CONTROL_B, 32'h81);
        `CHK("tx_ninth", 1'b1, tx_ninth_bit)
        pin("rx_abort", 1'b1);
        pin("rx_pin_override", 1'b0);
        rd(OFS_STATUS_A, 32'h0, "status");
        i_urb_frame_src.send(9'h077, 1'b1, 1'b0);
        rd(OFS_STATUS_A, 32'h0, "status");
        apb(1'b1, OFS_CONTROL_B, 32'h90);
        pin("rx_pin_override", 1'b1);
        rd(OFS_STATUS_A, 32'h0, "status");
        summarize();
    end
endmodule
